/* src/sfp_deglitch.sv */
// Purpose: Continuous-persistence filter for one fault condition
// Assumes: Condition synchronous to sys_clk
// Notes: Count restarts whenever the condition drops
`timescale 1ns/1ns
module sfp_deglitch #(
  parameter int CYCLES = 125
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cond,
  output logic filtered
);
  initial begin
    if (CYCLES < 1 || CYCLES > 255) $error("CYCLES out of range");
  end
  logic [sfp_pkg::DGL_W-1:0] cnt_reg, cnt_next;
  logic filt_reg, filt_next;
  localparam logic [sfp_pkg::DGL_W-1:0] LIM = sfp_pkg::DGL_W'(CYCLES - 1);
  always_comb begin
    cnt_next = cnt_reg;
    filt_next = filt_reg;
    if (!cond) begin
      cnt_next = '0;
      filt_next = 1'b0;
    end else if (cnt_reg == LIM) begin
      filt_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 8'h01;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      filt_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      filt_reg <= filt_next;
    end
  end
  assign filtered = filt_reg;
endmodule // sfp_deglitch

/* src/sfp_pkg.sv */
// Purpose: Shared constants for the switch fault-protection block
// Assumes: 25 MHz system clock
// Notes: Register offsets are byte addresses on the Avalon-MM slave
package sfp_pkg;
  localparam int CLK_MHZ = 25;
  localparam int NUM_CH = 5;
  // Times in their own units
  localparam int OTS_DGL_NS = 5000;
  localparam int UV_DGL_NS = 3500;
  localparam int CP_DGL_NS = 4000;
  localparam int BLANK_US = 50;
  localparam int RESTART_MS = 64;
  localparam int WIN1_US = 2000;
  localparam int WIN2_US = 8000;
  localparam int WIN3_US = 64000;
  // Derived cycle counts
  localparam int OTS_DGL_CYC = (OTS_DGL_NS * CLK_MHZ + 999) / 1000;
  localparam int UV_DGL_CYC = (UV_DGL_NS * CLK_MHZ + 999) / 1000;
  localparam int CP_DGL_CYC = (CP_DGL_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_CYC = BLANK_US * CLK_MHZ;
  localparam int RESTART_CYC = RESTART_MS * 1000 * CLK_MHZ;
  localparam int WIN1_CYC = WIN1_US * CLK_MHZ;
  localparam int WIN2_CYC = WIN2_US * CLK_MHZ;
  localparam int WIN3_CYC = WIN3_US * CLK_MHZ;
  localparam int DGL_W = 8;
  localparam int CNT_W = 24;
  // Register byte offsets
  localparam logic [4:0] OFS_QUICK = 5'h00;
  localparam logic [4:0] OFS_CH_STAT = 5'h04;
  localparam logic [4:0] OFS_DEV_STAT = 5'h08;
  localparam logic [4:0] OFS_CTRL = 5'h0C;
  localparam logic [4:0] OFS_CONFIG = 5'h10;
  localparam logic [4:0] OFS_CH_SEL = 5'h14;
  localparam logic [4:0] OFS_OUT = 5'h18;
  // Field positions
  localparam int QS_WARN = 0;
  localparam int QS_SHUT = 5;
  localparam int QS_PUMP = 10;
  localparam int QS_DSF = 11;
  localparam int CS_WARN = 0;
  localparam int CS_SHUT = 1;
  localparam int CS_DSF = 2;
  localparam int DS_LOW = 0;
  localparam int DS_HIGH = 1;
  localparam int DS_DSF = 2;
  localparam int CF_WSEL = 0;
  localparam int CF_FAIL = 1;
  localparam int CF_HALF = 2;
  localparam logic [31:0] UNMAPPED = 32'hDEADBEEF;
endpackage

/* src/sfp_top.sv */
// Purpose: Fault protection and diagnostic latches, five-channel switch
// Assumes: Comparator inputs synchronous to sys_clk
// Notes: Registers reached over Avalon-MM
`timescale 1ns/1ns
module sfp_top #(
  parameter int RESTART_CYCLES = sfp_pkg::RESTART_CYC,
  parameter int BLANK_CYCLES = sfp_pkg::BLANK_CYC,
  parameter int WIN1_CYCLES = sfp_pkg::WIN1_CYC,
  parameter int WIN2_CYCLES = sfp_pkg::WIN2_CYC,
  parameter int WIN3_CYCLES = sfp_pkg::WIN3_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [4:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic [4:0] tempWarnHigh,
  input wire logic [4:0] tempWarnLow,
  input wire logic [4:0] tempShutdown,
  input wire logic supplyLow,
  input wire logic supplyHigh,
  input wire logic pumpBad,
  input wire logic pumpSettled,
  output logic [4:0] outEnable,
  output logic [9:0] inrushWindow
);
  initial begin
    if (RESTART_CYCLES < 2 || RESTART_CYCLES >= (1 << sfp_pkg::CNT_W))
      $error("Bad restart count");
    if (BLANK_CYCLES < 1 || BLANK_CYCLES >= (1 << sfp_pkg::CNT_W))
      $error("Bad blank count");
  end

  // ****************************************
  // Fault filters
  // ****************************************
  logic [4:0] shutFilt;
  logic uvFilt, cpFilt;
  genvar g;
  generate
    for (g = 0; g < sfp_pkg::NUM_CH; g++) begin : gOts
      sfp_deglitch #(.CYCLES(sfp_pkg::OTS_DGL_CYC)) uOts (
        .sys_clk(sys_clk), .rst_b(rst_b), .cond(tempShutdown[g]),
        .filtered(shutFilt[g]));
    end
  endgenerate
  sfp_deglitch #(.CYCLES(sfp_pkg::UV_DGL_CYC)) uUv (
    .sys_clk(sys_clk), .rst_b(rst_b), .cond(supplyLow),
    .filtered(uvFilt));
  sfp_deglitch #(.CYCLES(sfp_pkg::CP_DGL_CYC)) uCp (
    .sys_clk(sys_clk), .rst_b(rst_b), .cond(pumpBad),
    .filtered(cpFilt));

  // ****************************************
  // Register and protection state
  // ****************************************
  logic [4:0] warnReg_reg, warnReg_next;
  logic [4:0] shutReg_reg, shutReg_next;
  logic [4:0] lockReg_reg, lockReg_next;
  logic lowReg_reg, lowReg_next;
  logic highReg_reg, highReg_next;
  logic pumpReg_reg, pumpReg_next;
  logic [4:0] onCmd_reg, onCmd_next;
  logic [4:0] outOn_reg, outOn_next;
  logic [2:0] cfg_reg, cfg_next;
  logic [2:0] chSel_reg, chSel_next;
  logic [sfp_pkg::CNT_W-1:0] blank_reg, blank_next;
  logic [sfp_pkg::CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic failPrev_reg, failPrev_next;

  logic blanked, wsel, failMode, half, device_fault_summary;
  logic [4:0] warnCond, startWin, pauseWin, shutEff;
  logic uvEff, cpEff, ovEff, req, wr, rd, restartTick;
  assign blanked = (blank_reg != '0);
  assign wsel = cfg_reg[sfp_pkg::CF_WSEL];
  assign failMode = cfg_reg[sfp_pkg::CF_FAIL];
  assign half = cfg_reg[sfp_pkg::CF_HALF];
  assign warnCond = wsel ? tempWarnLow : tempWarnHigh;
  assign shutEff = blanked ? 5'h00 : shutFilt;
  assign uvEff = uvFilt && !blanked;
  assign cpEff = cpFilt && !blanked;
  assign ovEff = supplyHigh && !blanked;
  assign device_fault_summary = lowReg_reg | highReg_reg | pumpReg_reg;
  assign req = (avsRead | avsWrite) && !ack_reg;
  assign wr = avsWrite && !ack_reg && avsByteEnable[0];
  assign rd = avsRead && !ack_reg;
  assign restartTick = failMode && (rst_cnt_reg == '0);

  function automatic logic [4:0] chMask(input logic [2:0] sel);
    chMask = (sel < 3'h5) ? 5'(5'h01 << sel) : 5'h00;
  endfunction

  always_comb begin
    warnReg_next = warnReg_reg | (blanked ? 5'h00 : warnCond);
    shutReg_next = shutReg_reg | shutEff;
    lowReg_next = lowReg_reg | uvEff;
    highReg_next = highReg_reg | ovEff;
    pumpReg_next = pumpReg_reg | cpEff;
    lockReg_next = lockReg_reg | (failMode ? shutEff : 5'h00);
    onCmd_next = onCmd_reg;
    cfg_next = cfg_reg;
    chSel_next = chSel_reg;
    blank_next = blanked ? blank_reg - 24'h000001 : blank_reg;
    rst_cnt_next = failMode ? ((rst_cnt_reg == '0)
      ? sfp_pkg::CNT_W'(RESTART_CYCLES - 1) : rst_cnt_reg - 24'h000001)
      : '0;
    failPrev_next = failMode;
    rdata_next = rdata_reg;
    ack_next = req;
    if (failPrev_reg != failMode)
      lockReg_next = failMode ? shutEff : 5'h00;
    if (rd) begin
      unique case (avsAddress)
        sfp_pkg::OFS_QUICK: begin
          rdata_next = '0;
          rdata_next[sfp_pkg::QS_WARN +: 5] = warnReg_reg;
          rdata_next[sfp_pkg::QS_SHUT +: 5] = shutReg_reg;
          rdata_next[sfp_pkg::QS_PUMP] = pumpReg_reg;
          rdata_next[sfp_pkg::QS_DSF] = device_fault_summary;
          pumpReg_next = cpEff;
        end
        sfp_pkg::OFS_CH_STAT: begin
          rdata_next = '0;
          if (chSel_reg < 3'h5) begin
            rdata_next[sfp_pkg::CS_WARN] = warnReg_reg[chSel_reg];
            rdata_next[sfp_pkg::CS_SHUT] = shutReg_reg[chSel_reg];
          end
          rdata_next[sfp_pkg::CS_DSF] = device_fault_summary;
          warnReg_next = (warnReg_reg & ~chMask(chSel_reg))
            | (blanked ? 5'h00 : warnCond);
          shutReg_next = (shutReg_reg & ~chMask(chSel_reg))
            | shutEff;
        end
        sfp_pkg::OFS_DEV_STAT: begin
          rdata_next = '0;
          rdata_next[sfp_pkg::DS_LOW] = lowReg_reg;
          rdata_next[sfp_pkg::DS_HIGH] = highReg_reg;
          rdata_next[sfp_pkg::DS_DSF] = device_fault_summary;
          lowReg_next = uvEff;
          highReg_next = ovEff;
        end
        sfp_pkg::OFS_CTRL: rdata_next = {27'h0, onCmd_reg};
        sfp_pkg::OFS_CONFIG: rdata_next = {29'h0, cfg_reg};
        sfp_pkg::OFS_CH_SEL: rdata_next = {29'h0, chSel_reg};
        sfp_pkg::OFS_OUT: rdata_next = {27'h0, outOn_reg};
        default: rdata_next = sfp_pkg::UNMAPPED;
      endcase
    end
    if (wr) begin
      unique case (avsAddress)
        sfp_pkg::OFS_CTRL: onCmd_next = avsWriteData[4:0];
        sfp_pkg::OFS_CONFIG: cfg_next = avsWriteData[2:0];
        sfp_pkg::OFS_CH_SEL: chSel_next = avsWriteData[2:0];
        default: ;
      endcase
    end
    // In normal mode shutdown and undervoltage drop the command, so a rewrite is needed
    if (!failMode) begin
      onCmd_next = onCmd_next & ~shutEff;
      if (uvEff) onCmd_next = 5'h00;
    end
    outOn_next = onCmd_next & ~lockReg_next & ~shutEff;
    if (failMode && !restartTick)
      outOn_next = outOn_next & (outOn_reg | ~onCmd_reg);
    if (uvEff || cpEff || !pumpSettled) outOn_next = 5'h00;
  end

  // Held commands start fresh windows when outputs come on
  assign startWin = outOn_next & ~outOn_reg;
  assign pauseWin = {5{uvEff | cpEff}} | shutEff;

  generate
    for (g = 0; g < sfp_pkg::NUM_CH; g++) begin : gWin
      sfp_window #(.W1(WIN1_CYCLES), .W2(WIN2_CYCLES),
        .W3(WIN3_CYCLES)) uWin (
        .sys_clk(sys_clk), .rst_b(rst_b), .start(startWin[g]),
        .run(outOn_reg[g]), .pause(pauseWin[g]), .half(half),
        .window(inrushWindow[2*g +: 2]));
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      warnReg_reg <= 5'h00;
      shutReg_reg <= 5'h00;
      lockReg_reg <= 5'h00;
      lowReg_reg <= 1'b0;
      highReg_reg <= 1'b0;
      pumpReg_reg <= 1'b0;
      onCmd_reg <= 5'h00;
      outOn_reg <= 5'h00;
      cfg_reg <= 3'h0;
      chSel_reg <= 3'h0;
      blank_reg <= sfp_pkg::CNT_W'(BLANK_CYCLES);
      rst_cnt_reg <= '0;
      rdata_reg <= 32'h00000000;
      ack_reg <= 1'b0;
      failPrev_reg <= 1'b0;
    end else begin
      warnReg_reg <= warnReg_next;
      shutReg_reg <= shutReg_next;
      lockReg_reg <= lockReg_next;
      lowReg_reg <= lowReg_next;
      highReg_reg <= highReg_next;
      pumpReg_reg <= pumpReg_next;
      onCmd_reg <= onCmd_next;
      outOn_reg <= outOn_next;
      cfg_reg <= cfg_next;
      chSel_reg <= chSel_next;
      blank_reg <= blank_next;
      rst_cnt_reg <= rst_cnt_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      failPrev_reg <= failPrev_next;
    end
  end

  assign avsWaitRequest = (avsRead | avsWrite) && !ack_reg;
  assign avsReadData = rdata_reg;
  assign outEnable = outOn_reg;
endmodule // sfp_top

/* src/sfp_window.sv */
// Purpose: Inrush window timer for one channel
// Assumes: Start pulse on each off-to-on transition
// Notes: Counting pauses while a fault is present
`timescale 1ns/1ns
module sfp_window #(
  parameter int W1 = 50000,
  parameter int W2 = 200000,
  parameter int W3 = 1600000
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic run,
  input wire logic pause,
  input wire logic half,
  output logic [1:0] window
);
  initial begin
    if (W1 < 2 || W3 >= (1 << sfp_pkg::CNT_W)) $error("Bad window");
  end
  logic [sfp_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic [1:0] win_reg, win_next;
  logic [sfp_pkg::CNT_W-1:0] lim;
  always_comb begin
    unique case (win_reg)
      2'h1: lim = sfp_pkg::CNT_W'(W1);
      2'h2: lim = sfp_pkg::CNT_W'(W2);
      default: lim = sfp_pkg::CNT_W'(W3);
    endcase
    if (half) lim = lim >> 1;
    cnt_next = cnt_reg;
    win_next = win_reg;
    if (start) begin
      cnt_next = '0;
      win_next = 2'h1;
    end else if (!run) begin
      win_next = 2'h0;
    end else if (win_reg != 2'h0 && !pause) begin
      if (cnt_reg + 24'h000001 >= lim) begin
        cnt_next = '0;
        win_next = (win_reg == 2'h3) ? 2'h0 : win_reg + 2'h1;
      end else begin
        cnt_next = cnt_reg + 24'h000001;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      win_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_next;
      win_reg <= win_next;
    end
  end
  assign window = win_reg;
endmodule // sfp_window

/* testbench/sfp_mcu.sv */
// Purpose: Microcontroller model on the register bus
// Assumes: Avalon-MM slave with waitrequest
// Notes: Requests change only right after a rising edge
`timescale 1ns/1ns
module sfp_mcu (
  input logic sys_clk,
  input logic avsWaitRequest,
  input logic [31:0] avsReadData,
  output logic [4:0] avsAddress,
  output logic avsRead,
  output logic avsWrite,
  output logic [31:0] avsWriteData,
  output logic [3:0] avsByteEnable,
  output logic hung
);
  // ****
  // Bus access
  // ****
  initial begin
    {avsAddress, avsRead, avsWrite, avsWriteData, hung} = '0;
    avsByteEnable = 4'hF;
  end
  // Normal-mode restarts are fresh writes of the on bits
  task automatic acc(input logic w, input logic [4:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= ~w;
    avsWriteData <= d;
    @(posedge sys_clk);
    while (avsWaitRequest !== 1'b0 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    q = avsReadData;
    hung <= (n >= 40);
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    avsAddress <= ~a;
    avsWriteData <= ~d;
    @(posedge sys_clk);
  endtask
endmodule // sfp_mcu

/* testbench/sfp_top_chk.sv */
// Purpose: Port assertions for sfp_top
// Assumes: One clock domain
// Notes: Counters measure fault persistence after blanking
`timescale 1ns/1ns
module sfp_top_chk #(
  parameter int RESTART_CYCLES = 200,
  parameter int BLANK_CYCLES = 20,
  parameter int WIN1_CYCLES = 40,
  parameter int WIN2_CYCLES = 80,
  parameter int WIN3_CYCLES = 160
) (
  input logic sys_clk,
  input logic rst_b,
  input logic [4:0] avsAddress,
  input logic avsRead,
  input logic avsWrite,
  input logic [31:0] avsWriteData,
  input logic [3:0] avsByteEnable,
  input logic [31:0] avsReadData,
  input logic avsWaitRequest,
  input logic [4:0] tempWarnHigh,
  input logic [4:0] tempWarnLow,
  input logic [4:0] tempShutdown,
  input logic supplyLow,
  input logic supplyHigh,
  input logic pumpBad,
  input logic pumpSettled,
  input logic [4:0] outEnable,
  input logic [9:0] inrushWindow
);
  // ****
  // Persistence counters
  // ****
  logic [15:0] age;
  logic [7:0] uvC, cpC, osC;
  logic live, ackRd;
  assign live = age > 16'(BLANK_CYCLES + 2);
  assign ackRd = avsRead && !avsWaitRequest;
  function automatic logic [7:0] up(logic [7:0] c, logic on);
    return on ? c + 8'(c != 8'hFF) : 8'h0;
  endfunction
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      age <= '0;
      {uvC, cpC, osC} <= '0;
    end else begin
      if (!live) age <= age + 16'h1;
      uvC <= up(uvC, live && supplyLow);
      cpC <= up(cpC, live && pumpBad);
      osC <= up(osC, live && tempShutdown[2]);
    end
  end
  // ****
  // Assertions
  // ****
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_wait_one: assert property ((avsRead || avsWrite) && avsWaitRequest
    |=> !avsWaitRequest) else $error("no answer after one wait");
  a_unmapped_read: assert property (ackRd && avsAddress == 5'h1C
    |-> avsReadData == sfp_pkg::UNMAPPED) else $error("bad unmapped data");
  a_uv_off: assert property (
    uvC > 8'd91 |-> outEnable == 5'h0) else $error("on in undervoltage");
  a_pump_off: assert property (
    cpC > 8'd103 |-> outEnable == 5'h0) else $error("on in pump fault");
  a_shut_off: assert property (
    osC > 8'd128 |-> !outEnable[2]) else $error("on in shutdown");
  a_unsettled_off: assert property (
    !pumpSettled [*2] |-> outEnable == 5'h0) else $error("on unsettled");
  a_low_flag: assert property (
    ackRd && avsAddress == sfp_pkg::OFS_DEV_STAT && uvC > 8'd93
    |-> avsReadData[2] && avsReadData[0]) else $error("low flag missing");
  a_pump_flag: assert property (
    ackRd && avsAddress == sfp_pkg::OFS_QUICK && cpC > 8'd106
    |-> avsReadData[11:10] == 2'b11) else $error("pump flag missing");
  c_uv: cover property (uvC == 8'd95);
  c_unmapped: cover property (ackRd && avsAddress == 5'h1C);
  c_shut: cover property ($fell(outEnable[2]));
endmodule // sfp_top_chk

/* testbench/tb_sfp_top.sv */
// Purpose: Self-checking bench for sfp_top
// Assumes: Shortened timer parameters
// Notes: Expected values are written by hand into the scenario
`timescale 1ns/1ns
module tb_sfp_top;
  // ****
  // Signals and instances
  // ****
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [4:0] avsAddress, tempWarnHigh, tempWarnLow, tempShutdown, outEnable;
  logic avsRead, avsWrite, avsWaitRequest, hung;
  logic supplyLow, supplyHigh, pumpBad, pumpSettled;
  logic [31:0] avsWriteData, avsReadData, q;
  logic [3:0] avsByteEnable;
  logic [9:0] inrushWindow;
  int n_fail = 0, checks_done = 0, seed = 32'h22c7, ch, expOn, warnQ;
  always #20 sys_clk = ~sys_clk;
  sfp_top #(.RESTART_CYCLES(200), .BLANK_CYCLES(20), .WIN1_CYCLES(40),
    .WIN2_CYCLES(80), .WIN3_CYCLES(160)) i_sfp_top (.sys_clk, .rst_b,
    .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
    .avsReadData, .avsWaitRequest, .tempWarnHigh, .tempWarnLow,
    .tempShutdown, .supplyLow, .supplyHigh, .pumpBad, .pumpSettled,
    .outEnable, .inrushWindow);
  sfp_mcu i_sfp_mcu (.sys_clk, .avsWaitRequest, .avsReadData, .avsAddress,
    .avsRead, .avsWrite, .avsWriteData, .avsByteEnable, .hung);
  // ****
  // Tasks
  // ****
  task automatic cmpReg(input logic [31:0] got, input logic [31:0] e);
    checks_done++;
    if (got !== e) begin
      n_fail++;
      $display("unexpected at %0t: register %h not %h", $time, got, e);
    end
  endtask
  task automatic cmpPin(input logic [9:0] got, input logic [9:0] e);
    checks_done++;
    if (got !== e) begin
      n_fail++;
      $display("unexpected at %0t: pins %h not %h", $time, got, e);
    end
  endtask
  task automatic rdChk(input logic [4:0] a, input logic [31:0] e);
    i_sfp_mcu.acc(1'b0, a, 32'h0, q);
    cmpReg(q, e);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    i_sfp_mcu.acc(1'b1, a, d, q);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge hung) begin
    n_fail++;
    $display("unexpected at %0t: bus answer timed out", $time);
    summarize();
  end
  initial begin
    cyc(60000);
    n_fail++;
    $display("unexpected at %0t: run timed out", $time);
    summarize();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    {tempWarnHigh, tempWarnLow, tempShutdown} = '0;
    {supplyLow, supplyHigh, pumpBad, pumpSettled} = '0;
    cyc(5);
    rst_b <= 1'b1;
    supplyHigh <= 1'b1;
    cyc(2);
    rdChk(sfp_pkg::OFS_CONFIG, 0);
    rdChk(5'h1C, sfp_pkg::UNMAPPED);
    wr(sfp_pkg::OFS_CTRL, 32'h1F);
    expOn = 'h1F;
    cyc(5);
    cmpPin(outEnable, 0);
    pumpSettled <= 1'b1;
    supplyHigh <= 1'b0;
    cyc(3);
    cmpPin(outEnable, expOn);
    cmpPin(inrushWindow, 10'h155);
    rdChk(sfp_pkg::OFS_DEV_STAT, 0);
    cyc(50);
    cmpPin(inrushWindow, 10'h2AA);
    cyc(80);
    cmpPin(inrushWindow, 10'h3FF);
    ch = {$random(seed)} % 5;
    tempWarnLow <= 5'h1F;
    cyc(4);
    rdChk(sfp_pkg::OFS_QUICK, 0);
    tempWarnHigh[ch] <= 1'b1;
    cyc(4);
    rdChk(sfp_pkg::OFS_QUICK, 1 << ch);
    cmpPin(outEnable, expOn);
    wr(sfp_pkg::OFS_CONFIG, 1);
    cyc(3);
    rdChk(sfp_pkg::OFS_QUICK, 32'h1F);
    wr(sfp_pkg::OFS_CH_SEL, ch);
    rdChk(sfp_pkg::OFS_CH_STAT, 1);
    {tempWarnHigh, tempWarnLow} <= '0;
    cyc(3);
    rdChk(sfp_pkg::OFS_CH_STAT, 1);
    rdChk(sfp_pkg::OFS_CH_STAT, 0);
    warnQ = 32'h1F & ~(1 << ch);
    wr(sfp_pkg::OFS_CONFIG, 0);
    tempShutdown[2] <= 1'b1;
    cyc(120);
    tempShutdown[2] <= 1'b0;
    cyc(1);
    tempShutdown[2] <= 1'b1;
    cyc(122);
    cmpPin(outEnable, expOn);
    cyc(6);
    expOn = 'h1B;
    cmpPin(outEnable, expOn);
    rdChk(sfp_pkg::OFS_QUICK, warnQ | 32'h80);
    rdChk(sfp_pkg::OFS_CTRL, expOn);
    tempShutdown[2] <= 1'b0;
    cyc(2);
    wr(sfp_pkg::OFS_CH_SEL, 2);
    rdChk(sfp_pkg::OFS_CH_STAT, 2 | warnQ[2]);
    rdChk(sfp_pkg::OFS_CH_STAT, 0);
    warnQ[2] = 1'b0;
    cmpPin(outEnable, expOn);
    wr(sfp_pkg::OFS_CTRL, 32'h1F);
    cyc(2);
    cmpPin(outEnable, 5'h1F);
    supplyLow <= 1'b1;
    cyc(95);
    cmpPin(outEnable, 0);
    rdChk(sfp_pkg::OFS_DEV_STAT, 5);
    supplyLow <= 1'b0;
    cyc(2);
    rdChk(sfp_pkg::OFS_DEV_STAT, 5);
    rdChk(sfp_pkg::OFS_DEV_STAT, 0);
    cmpPin(outEnable, 0);
    supplyHigh <= 1'b1;
    cyc(3);
    rdChk(sfp_pkg::OFS_DEV_STAT, 6);
    supplyHigh <= 1'b0;
    cyc(2);
    rdChk(sfp_pkg::OFS_DEV_STAT, 6);
    rdChk(sfp_pkg::OFS_DEV_STAT, 0);
    pumpBad <= 1'b1;
    cyc(106);
    wr(sfp_pkg::OFS_CTRL, 32'h15);
    cmpPin(outEnable, 0);
    rdChk(sfp_pkg::OFS_QUICK, warnQ | 32'hC00);
    pumpBad <= 1'b0;
    cyc(3);
    cmpPin(outEnable, 5'h15);
    cmpPin(inrushWindow, 10'h111);
    rdChk(sfp_pkg::OFS_QUICK, warnQ | 32'hC00);
    rdChk(sfp_pkg::OFS_QUICK, warnQ);
    wr(sfp_pkg::OFS_CONFIG, 4);
    wr(sfp_pkg::OFS_CTRL, 0);
    wr(sfp_pkg::OFS_CTRL, 1);
    cyc(28);
    cmpPin(inrushWindow, 10'h2);
    wr(sfp_pkg::OFS_CONFIG, 2);
    wr(sfp_pkg::OFS_CTRL, 32'h1F);
    tempShutdown[3] <= 1'b1;
    cyc(130);
    tempShutdown[3] <= 1'b0;
    supplyLow <= 1'b1;
    cyc(95);
    cmpPin(outEnable, 0);
    supplyLow <= 1'b0;
    cyc(210);
    cmpPin(outEnable, 5'h17);
    summarize();
  end
endmodule // tb_sfp_top
bind sfp_top sfp_top_chk #(.RESTART_CYCLES(RESTART_CYCLES),
  .BLANK_CYCLES(BLANK_CYCLES), .WIN1_CYCLES(WIN1_CYCLES),
  .WIN2_CYCLES(WIN2_CYCLES), .WIN3_CYCLES(WIN3_CYCLES)) i_chk (.sys_clk,
  .rst_b, .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable,
  .avsReadData, .avsWaitRequest, .tempWarnHigh, .tempWarnLow, .tempShutdown,
  .supplyLow, .supplyHigh, .pumpBad, .pumpSettled, .outEnable,
  .inrushWindow);
